/* src/framer_pkg.sv */
// Purpose: constants for the framer status and interrupt unit
// Assumes: byte-wide special function register access at fixed addresses
// Notes: field positions, reset values and bit run lengths live here
//
// Operation
// - overrun keeps older unread byte, flags overrun
// - completed byte loads holding register, raises ready
// - flag, abort, idle never become data
// - misaligned unstuffed flag sets misaligned status
// - seven ones after activity set abort status
// - fifteen ones after activity set idle status
// - unstuffed flag pattern sets flag status
// - status clears on reset and on read
// - enable bit 7 gates transmit-ready interrupt
// - enable bit 6 gates receive-ready interrupt
// - enable bit 5 premasks transmit-ready and underrun
// - transmit-ready on message bytes, never CRC bytes
// - enable bit 4 premasks receive-ready and overrun
// - enable bits 3:0 gate four line statuses
// - new-status follows unmasked status, clears on read
// - interrupt when new-status or gated ready source set and global enable
// - receive-ready clears on reset, holding read
// - transmit-ready set at byte start with control
// - transmit-ready clears on reset, holding write
// - holding byte destuffed, first bit in bit 0
// - holding byte sent next boundary when sending
// - global enable off suppresses interrupt, keeps status
// - underrun when sending data only without fresh byte
package framer_pkg;

  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] STATUS_ADDR = 8'hc3;
  localparam logic [7:0] IRQ_ENABLE_ADDR = 8'hc4;
  localparam logic [7:0] IRQ_SOURCE_ADDR = 8'hc5;
  localparam logic [7:0] RX_HOLD_ADDR = 8'hc6;
  localparam logic [7:0] TX_HOLD_ADDR = 8'hc7;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ST_CRC32 = 7;
  localparam int ST_CRC16 = 6;
  localparam int ST_UNDERRUN = 5;
  localparam int ST_OVERRUN = 4;
  localparam int IE_TX_GATE = 7;
  localparam int IE_RX_GATE = 6;
  localparam int IE_TX_EN = 5;
  localparam int IE_RX_EN = 4;
  localparam int SRC_NEW = 2;
  localparam int SRC_RX = 1;
  localparam int SRC_TX = 0;
  localparam int CTL_SEND_DATA = 1;

  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
  localparam logic [2:0] IRQ_SOURCE_RST = 3'h0;
  localparam logic [3:0] TXCTL_DATA_ONLY = 4'h2;
  localparam logic [1:0] CRC_UNMASK = 2'h3;

  // ---------------------------------------------------------------
  // line pattern run lengths and byte positions
  // ---------------------------------------------------------------
  localparam logic [3:0] RUN_STUFF = 4'h5;
  localparam logic [3:0] RUN_FLAG = 4'h6;
  localparam logic [3:0] RUN_ABORT_PRE = 4'h6;
  localparam logic [3:0] RUN_IDLE_PRE = 4'he;
  localparam logic [3:0] RUN_MAX = 4'hf;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_SHARED = 3'h6;

  // ---------------------------------------------------------------
  // event indices across the clock crossing
  // ---------------------------------------------------------------
  localparam int EV_FLAG = 0;
  localparam int EV_IDLE = 1;
  localparam int EV_ABORT = 2;
  localparam int EV_INVAL = 3;
  localparam int EV_BYTE = 4;
  localparam int EV_TX = 5;
  localparam int EV_COUNT = 6;

endpackage : framer_pkg

/* src/hdlc_status_interrupt_unit.sv */
// Purpose: receive pattern detection, status, interrupt and holding regs
// Assumes: receive line sampled on rxClk, serializer runs on txClk
// Notes: line events cross into mclk by toggles and three-flop chains
`timescale 1ns/1ps
module hdlc_status_interrupt_unit (
  input wire logic mclk, // processor clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic [7:0] sfrAddr, // register address
  input wire logic [7:0] sfrWrData, // register write data
  input wire logic sfrWr, // write strobe
  input wire logic sfrRd, // read strobe
  output logic [7:0] sfrRdData, // registered read data
  input wire logic globalIrqEn, // control one bit 0
  input wire logic zeroDelEn, // control one bit 1, zero delete
  input wire logic [3:0] txCtrl, // transmit control bits 3:0
  input wire logic crc16Bad, // crc16 check failed pulse
  input wire logic crc32Bad, // crc32 check failed pulse
  input wire logic rxClk, // receive serial clock
  input wire logic rxBit, // receive serial data
  input wire logic txClk, // transmit serial clock
  input wire logic txByteStart, // serializer first bit of a byte
  input wire logic txCrcByte, // serializer sends crc byte
  output logic [7:0] txHoldByte, // transmit holding byte
  output logic sendDataClr, // pulse: clear send-data on underrun
  output logic hdlcIrq // interrupt request, active high
);

  // ---------------------------------------------------------------
  // receive domain
  // ---------------------------------------------------------------
  logic [1:0] rxRstSh_r;
  logic zdS1_r;
  logic zdS2_r;
  logic [3:0] onesCnt_r;
  logic [2:0] bitCnt_r;
  logic [7:0] dataSh_r;
  logic hunt_r;
  logic active_r;
  logic afterFlag_r;
  logic [7:0] rxByte_r;
  logic [4:0] rxTog_r;
  logic rxRstN;
  logic [3:0] onesNxt;
  logic flagHit;
  logic stuffBit;
  logic abortHit;
  logic idleHit;
  logic invalHit;
  logic byteDone;
  logic [7:0] byteVal;

  assign rxRstN = rxRstSh_r[1];

  // reset and zero-delete enable brought into the receive domain
  always_ff @(posedge rxClk) begin
    rxRstSh_r <= {rxRstSh_r[0], nrst};
    zdS1_r <= zeroDelEn;
    zdS2_r <= zdS1_r;
  end

  // line pattern decode from the ones run length
  assign onesNxt = rxBit ? ((onesCnt_r == framer_pkg::RUN_MAX) ?
                   framer_pkg::RUN_MAX : 4'(onesCnt_r + 4'h1)) : 4'h0;
  assign flagHit = !rxBit && onesCnt_r == framer_pkg::RUN_FLAG;
  assign stuffBit = !rxBit && onesCnt_r == framer_pkg::RUN_STUFF &&
                    zdS2_r;
  assign abortHit = rxBit && active_r &&
                    onesCnt_r == framer_pkg::RUN_ABORT_PRE;
  assign idleHit = rxBit && active_r &&
                   onesCnt_r == framer_pkg::RUN_IDLE_PRE;
  assign invalHit = flagHit && !hunt_r &&
                    bitCnt_r != framer_pkg::BIT_LAST &&
                    !(afterFlag_r && bitCnt_r == framer_pkg::BIT_SHARED);
  assign byteVal = {rxBit, dataSh_r[7:1]};
  assign byteDone = !stuffBit && !flagHit && !hunt_r &&
                    bitCnt_r == framer_pkg::BIT_LAST &&
                    !(rxBit && onesCnt_r >= framer_pkg::RUN_STUFF);

  // run counter, byte alignment and event toggles
  always_ff @(posedge rxClk) begin
    if (!rxRstN) begin
      onesCnt_r <= 4'h0;
      bitCnt_r <= 3'h0;
      dataSh_r <= 8'h00;
      hunt_r <= 1'b1;
      active_r <= 1'b0;
      afterFlag_r <= 1'b0;
      rxTog_r <= 5'h00;
    end else begin
      onesCnt_r <= onesNxt;
      if (flagHit) begin
        bitCnt_r <= 3'h0;
      end else if (!stuffBit) begin
        bitCnt_r <= 3'(bitCnt_r + 3'h1);
      end
      if (!stuffBit) begin
        dataSh_r <= byteVal;
      end
      if (flagHit) begin
        hunt_r <= 1'b0;
      end else if (abortHit) begin
        hunt_r <= 1'b1;
      end
      if (!rxBit) begin
        active_r <= 1'b1;
      end else if (idleHit) begin
        active_r <= 1'b0;
      end
      if (flagHit) begin
        afterFlag_r <= 1'b1;
      end else if (byteDone) begin
        afterFlag_r <= 1'b0;
      end
      rxTog_r <= rxTog_r ^ {byteDone, invalHit, abortHit, idleHit,
                            flagHit};
    end
  end

  // completed byte held stable until the next one
  always_ff @(posedge rxClk) begin
    if (byteDone) begin
      rxByte_r <= byteVal;
    end
  end

  // ---------------------------------------------------------------
  // transmit domain
  // ---------------------------------------------------------------
  logic [1:0] txRstSh_r;
  logic txTog_r;

  // message byte starts only; crc bytes never count
  always_ff @(posedge txClk) begin
    txRstSh_r <= {txRstSh_r[0], nrst};
    if (!txRstSh_r[1]) begin
      txTog_r <= 1'b0;
    end else if (txByteStart && !txCrcByte) begin
      txTog_r <= !txTog_r;
    end
  end

  // ---------------------------------------------------------------
  // crossing into the processor domain
  // ---------------------------------------------------------------
  logic [framer_pkg::EV_COUNT-1:0] togIn;
  logic [framer_pkg::EV_COUNT-1:0] togS1_r;
  logic [framer_pkg::EV_COUNT-1:0] togS2_r;
  logic [framer_pkg::EV_COUNT-1:0] togS3_r;
  logic [framer_pkg::EV_COUNT-1:0] evPulse;

  assign togIn = {txTog_r, rxTog_r};

  // three flops per event, edge taken between second and third
  generate
    for (genvar i = 0; i < framer_pkg::EV_COUNT; i++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (!nrst) begin
          togS1_r[i] <= 1'b0;
          togS2_r[i] <= 1'b0;
          togS3_r[i] <= 1'b0;
        end else begin
          togS1_r[i] <= togIn[i];
          togS2_r[i] <= togS1_r[i];
          togS3_r[i] <= togS2_r[i];
        end
      end
      assign evPulse[i] = togS2_r[i] ^ togS3_r[i];
    end
  endgenerate

  // ---------------------------------------------------------------
  // register decode and next values
  // ---------------------------------------------------------------
  logic [7:0] status_r;
  logic [7:0] ie_r;
  logic [2:0] src_r;
  logic [7:0] rxHold_r;
  logic rxFull_r;
  logic [7:0] txHold_r;
  logic txFresh_r;
  logic [7:0] rdData_r;
  logic sendDataClr_r;
  logic irq_r;
  logic rdStat;
  logic rdRx;
  logic wrIe;
  logic wrTx;
  logic byteEv;
  logic txEv;
  logic rxLoad;
  logic ovrnSet;
  logic undSet;
  logic [7:0] statusSet;
  logic [7:0] unmask;
  logic [7:0] statusNxt;
  logic [2:0] srcNxt;
  logic irqNxt;
  logic [7:0] rdMux;

  assign rdStat = sfrRd && sfrAddr == framer_pkg::STATUS_ADDR;
  assign rdRx = sfrRd && sfrAddr == framer_pkg::RX_HOLD_ADDR;
  assign wrIe = sfrWr && sfrAddr == framer_pkg::IRQ_ENABLE_ADDR;
  assign wrTx = sfrWr && sfrAddr == framer_pkg::TX_HOLD_ADDR;
  assign byteEv = evPulse[framer_pkg::EV_BYTE];
  assign txEv = evPulse[framer_pkg::EV_TX];

  // receive hand-off: load when empty, otherwise overrun
  assign rxLoad = byteEv && !rxFull_r;
  assign ovrnSet = byteEv && rxFull_r;
  // underrun: sending data only, no fresh byte at the boundary
  assign undSet = txEv && txCtrl[framer_pkg::CTL_SEND_DATA] &&
                  !txFresh_r && txCtrl == framer_pkg::TXCTL_DATA_ONLY;

  // status sets win over the read clear
  assign statusSet = {crc32Bad, crc16Bad, undSet, ovrnSet,
                      evPulse[framer_pkg::EV_INVAL],
                      evPulse[framer_pkg::EV_ABORT],
                      evPulse[framer_pkg::EV_IDLE],
                      evPulse[framer_pkg::EV_FLAG]};
  assign statusNxt = (status_r & ~{8{rdStat}}) | statusSet;
  assign unmask = {framer_pkg::CRC_UNMASK, ie_r[framer_pkg::IE_TX_EN],
                   ie_r[framer_pkg::IE_RX_EN], ie_r[3:0]};

  // source bits: new status, receive ready, transmit ready
  assign srcNxt[framer_pkg::SRC_NEW] =
    (src_r[framer_pkg::SRC_NEW] && !rdStat) ||
    |(statusSet & unmask);
  assign srcNxt[framer_pkg::SRC_RX] =
    (src_r[framer_pkg::SRC_RX] && !rdRx) ||
    (rxLoad && ie_r[framer_pkg::IE_RX_EN]);
  assign srcNxt[framer_pkg::SRC_TX] =
    (src_r[framer_pkg::SRC_TX] && !wrTx) ||
    (txEv && ie_r[framer_pkg::IE_TX_EN] && |txCtrl);

  // interrupt from source bits through the gates and global enable
  assign irqNxt = globalIrqEn && (src_r[framer_pkg::SRC_NEW] ||
    (src_r[framer_pkg::SRC_RX] && ie_r[framer_pkg::IE_RX_GATE]) ||
    (src_r[framer_pkg::SRC_TX] && ie_r[framer_pkg::IE_TX_GATE]));

  // read data select, unmapped and write-only read as zero
  assign rdMux = (sfrAddr == framer_pkg::STATUS_ADDR) ? status_r :
                 (sfrAddr == framer_pkg::IRQ_ENABLE_ADDR) ? ie_r :
                 (sfrAddr == framer_pkg::IRQ_SOURCE_ADDR) ?
                 {5'h00, src_r} :
                 (sfrAddr == framer_pkg::RX_HOLD_ADDR) ? rxHold_r : 8'h00;

  // ---------------------------------------------------------------
  // processor domain registers
  // ---------------------------------------------------------------

  // control and status flops
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      status_r <= framer_pkg::STATUS_RST;
      ie_r <= framer_pkg::IRQ_ENABLE_RST;
      src_r <= framer_pkg::IRQ_SOURCE_RST;
      rxFull_r <= 1'b0;
      txFresh_r <= 1'b0;
      rdData_r <= 8'h00;
      sendDataClr_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      status_r <= statusNxt;
      if (wrIe) begin
        ie_r <= sfrWrData;
      end
      src_r <= srcNxt;
      rxFull_r <= rxLoad || (rxFull_r && !rdRx);
      txFresh_r <= wrTx || (txFresh_r && !txEv);
      if (sfrRd) begin
        rdData_r <= rdMux;
      end
      sendDataClr_r <= undSet;
      irq_r <= irqNxt;
    end
  end

  // holding registers carry no reset value
  always_ff @(posedge mclk) begin
    if (rxLoad) begin
      rxHold_r <= rxByte_r;
    end
    if (wrTx) begin
      txHold_r <= sfrWrData;
    end
  end

  assign sfrRdData = rdData_r;
  assign txHoldByte = txHold_r;
  assign sendDataClr = sendDataClr_r;
  assign hdlcIrq = irq_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  a_overrun_keeps_old: assert property (
    ovrnSet |=> status_r[framer_pkg::ST_OVERRUN] && $stable(rxHold_r))
    else $error("overrun replaced unread byte");

  a_rx_load_byte: assert property (
    rxLoad |=> rxFull_r && rxHold_r == $past(rxByte_r))
    else $error("received byte not loaded");

  a_status_read_clr: assert property (
    rdStat && statusSet == 8'h00 |=> status_r == 8'h00)
    else $error("status not cleared by read");

  a_tx_gate_irq: assert property (
    src_r[framer_pkg::SRC_TX] && ie_r[framer_pkg::IE_TX_GATE] &&
    globalIrqEn |=> hdlcIrq)
    else $error("transmit ready did not interrupt");

  a_tx_premask: assert property (
    !ie_r[framer_pkg::IE_TX_EN] && !src_r[framer_pkg::SRC_TX] |=>
    !src_r[framer_pkg::SRC_TX])
    else $error("transmit ready set while premasked");

  a_rx_premask: assert property (
    !ie_r[framer_pkg::IE_RX_EN] && !src_r[framer_pkg::SRC_RX] |=>
    !src_r[framer_pkg::SRC_RX])
    else $error("receive ready set while premasked");

  // a status read right after the event may clear it one cycle later
  a_new_status_set: assert property (
    |(statusSet & unmask) |=> src_r[framer_pkg::SRC_NEW] ##1
    (src_r[framer_pkg::SRC_NEW] || $past(rdStat)))
    else $error("new status not held after unmasked event");

  // event index matches the status bit it sets
  a_flag_status: assert property (
    evPulse[framer_pkg::EV_FLAG] |=> status_r[framer_pkg::EV_FLAG])
    else $error("flag event not in status");

  a_abort_status: assert property (
    evPulse[framer_pkg::EV_ABORT] |=> status_r[framer_pkg::EV_ABORT])
    else $error("abort event not in status");

  a_idle_status: assert property (
    evPulse[framer_pkg::EV_IDLE] |=> status_r[framer_pkg::EV_IDLE])
    else $error("idle event not in status");

  a_inval_status: assert property (
    evPulse[framer_pkg::EV_INVAL] |=> status_r[framer_pkg::EV_INVAL])
    else $error("misaligned flag not in status");

  a_rx_ready_clr: assert property (
    rdRx && !rxLoad |=> !src_r[framer_pkg::SRC_RX])
    else $error("receive ready not cleared by read");

  a_irq_src_zero: assert property (
    src_r == 3'h0 |=> !hdlcIrq)
    else $error("interrupt with no source bit");

  a_tx_ready_set: assert property (
    txEv && ie_r[framer_pkg::IE_TX_EN] && txCtrl != 4'h0 |=>
    src_r[framer_pkg::SRC_TX])
    else $error("transmit ready not set at byte start");

  a_global_off_quiet: assert property (
    !globalIrqEn [*2] |-> !hdlcIrq)
    else $error("interrupt while globally disabled");

  a_tx_ready_clr: assert property (
    wrTx && !txEv |=> !src_r[framer_pkg::SRC_TX])
    else $error("transmit ready not cleared by write");

  a_underrun_flag: assert property (
    undSet |=> status_r[framer_pkg::ST_UNDERRUN] && sendDataClr)
    else $error("underrun not flagged");

  c_overrun: cover property (ovrnSet);
  c_rx_ready: cover property (rxLoad);
  c_flag_event: cover property (evPulse[framer_pkg::EV_FLAG]);
  c_irq_rise: cover property ($rose(hdlcIrq));
  c_underrun: cover property (undSet);

endmodule : hdlc_status_interrupt_unit

/* testbench/link_model.sv */
// Purpose: modem data pump model on the receive and transmit serial side
// Assumes: serial clocks stand still outside frames, 48 ns period
// Notes: data bytes are zero stuffed here, flags and raw runs are not
`timescale 1ns/1ps
module link_model (
  output logic rxClk, // receive serial clock
  output logic rxBit, // receive serial data
  output logic txClk, // transmit serial clock
  output logic txByteStart, // first bit of a byte leaves
  output logic txCrcByte // current byte is crc
);
  int ones = 0;

  // idle lines, clocks stopped
  initial begin
    rxClk = 1'b0;
    rxBit = 1'b1;
    txClk = 1'b0;
    txByteStart = 1'b0;
    txCrcByte = 1'b0;
  end

  // one bit, set up half a period before the sampling edge
  task automatic putBit(input logic b);
    rxBit = b;
    #24 rxClk = 1'b1;
    #24 rxClk = 1'b0;
  endtask : putBit

  // lsb first, a zero after five ones when stuffing
  task automatic bits(input logic [15:0] v, input int n, input bit stuff);
    for (int i = 0; i < n; i++) begin
      putBit(v[i]);
      ones = (stuff && v[i]) ? ones + 1 : 0;
      if (ones == 5) begin
        putBit(1'b0);
        ones = 0;
      end
    end
  endtask : bits

  // both clocks run with the line at ones, used around reset
  task automatic spin(input int n);
    rxBit = 1'b1;
    repeat (n) begin
      #24 rxClk = 1'b1;
      txClk = 1'b1;
      #24 rxClk = 1'b0;
      txClk = 1'b0;
    end
  endtask : spin

  // one transmitted byte: start pulse, eight link clocks in all
  task automatic txByte(input logic crc);
    txCrcByte = crc;
    txByteStart = 1'b1;
    repeat (8) begin
      #24 txClk = 1'b1;
      #24 txClk = 1'b0;
      txByteStart = 1'b0;
    end
    txCrcByte = 1'b0;
  endtask : txByte
endmodule : link_model

/* testbench/tb_top.sv */
// Purpose: self-checking bench for the framer status and interrupt unit
// Assumes: registers reached by one-cycle read and write strobes
// Notes: reads queue their expected byte, a monitor compares later
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] ST = framer_pkg::STATUS_ADDR;
  localparam logic [7:0] IE = framer_pkg::IRQ_ENABLE_ADDR;
  localparam logic [7:0] SRC = framer_pkg::IRQ_SOURCE_ADDR;
  localparam logic [7:0] RXH = framer_pkg::RX_HOLD_ADDR;
  localparam logic [7:0] TXH = framer_pkg::TX_HOLD_ADDR;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] sfrAddr = 8'h00;
  logic [7:0] sfrWrData = 8'h00;
  logic sfrWr = 1'b0;
  logic sfrRd = 1'b0;
  logic [7:0] sfrRdData;
  logic globalIrqEn = 1'b0;
  logic zeroDelEn = 1'b1;
  logic [3:0] txCtrl = 4'h0;
  logic crc16Bad = 1'b0;
  logic crc32Bad = 1'b0;
  logic rxClk, rxBit, txClk, txByteStart, txCrcByte;
  logic [7:0] txHoldByte;
  logic sendDataClr, hdlcIrq;
  logic rdSeen = 1'b0;
  logic [7:0] expQ[$];
  logic [7:0] d;
  int mismatches = 0;
  int total_checks = 0;
  int clrCount = 0;

  hdlc_status_interrupt_unit dut (.mclk(mclk), .nrst(nrst),
    .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrWr(sfrWr),
    .sfrRd(sfrRd), .sfrRdData(sfrRdData), .globalIrqEn(globalIrqEn),
    .zeroDelEn(zeroDelEn), .txCtrl(txCtrl), .crc16Bad(crc16Bad),
    .crc32Bad(crc32Bad), .rxClk(rxClk), .rxBit(rxBit), .txClk(txClk),
    .txByteStart(txByteStart), .txCrcByte(txCrcByte),
    .txHoldByte(txHoldByte), .sendDataClr(sendDataClr), .hdlcIrq(hdlcIrq));
  link_model partner (.rxClk(rxClk), .rxBit(rxBit), .txClk(txClk),
    .txByteStart(txByteStart), .txCrcByte(txCrcByte));

  // processor clock, 20 ns
  initial begin
    forever #10 mclk = ~mclk;
  end

  // compare one value, count and report
  task automatic chk(input string nm, input logic [7:0] s, e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // read data lands the cycle after the read edge
  always @(posedge mclk) begin
    if (rdSeen === 1'b1)
      chk("sfrRdData", sfrRdData, expQ.pop_front());
    if (sendDataClr === 1'b1)
      clrCount++;
    rdSeen <= sfrRd;
  end

  // register write, one-cycle strobe
  task automatic wr(input logic [7:0] a, v);
    @(negedge mclk);
    sfrAddr = a;
    sfrWrData = v;
    sfrWr = 1'b1;
    @(negedge mclk);
    sfrWr = 1'b0;
  endtask : wr

  // register read, expected byte queued for the monitor
  task automatic rd(input logic [7:0] a, e);
    @(negedge mclk);
    sfrAddr = a;
    sfrRd = 1'b1;
    expQ.push_back(e);
    @(negedge mclk);
    sfrRd = 0;
  endtask : rd

  // let link events cross into the processor domain
  task automatic settle();
    repeat (12) @(negedge mclk);
  endtask : settle

  // flag then one stuffed data byte
  task automatic rxFrame(input logic [7:0] v);
    partner.bits(16'h007e, 8, 1'b0);
    partner.bits({8'h00, v}, 8, 1'b1);
    settle();
  endtask : rxFrame

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // watchdog
  initial begin
    #400000;
    mismatches++;
    print_verdict();
  end

  // main sequence
  initial begin
    void'($urandom(36483));
    fork
      partner.spin(8);
      repeat (10) @(negedge mclk);
    join
    @(negedge mclk);
    nrst = 1'b1;
    // serial domains leave reset two link edges after release
    partner.spin(4);
    rd(ST, 8'h00);
    rd(SRC, 8'h00);
    rd(8'hc0, 8'h00);
    rd(TXH, 8'h00);
    wr(ST, 8'hff);
    wr(IE, 8'hff);
    rd(IE, 8'hff);
    globalIrqEn = 1'b1;
    d = 8'(($urandom() | 32'h1f) & 32'hff);
    rxFrame(d);
    rd(SRC, 8'h06);
    chk("hdlcIrq", {7'h0, hdlcIrq}, 8'h01);
    rd(ST, 8'h01);
    rd(RXH, d);
    rd(SRC, 8'h00);
    chk("hdlcIrq", {7'h0, hdlcIrq}, 8'h00);
    partner.bits({8'h00, d}, 8, 1'b1);
    partner.bits(16'h00a5, 8, 1'b1);
    settle();
    rd(ST, 8'h10);
    rd(RXH, d);
    partner.bits(16'h3f7e, 15, 1'b0);
    settle();
    rd(SRC, 8'h04);
    rd(ST, 8'h01);
    partner.bits(16'h00fc, 9, 1'b0);
    settle();
    rd(ST, 8'h09);
    partner.bits(16'h7fff, 15, 1'b0);
    settle();
    rd(SRC, 8'h04);
    rd(ST, 8'h06);
    wr(IE, 8'h00);
    d = 8'($urandom() & 32'hff);
    rxFrame(d);
    rd(SRC, 8'h00);
    chk("hdlcIrq", {7'h0, hdlcIrq}, 8'h00);
    rd(ST, 8'h01);
    rd(RXH, d);
    wr(IE, 8'hbf);
    globalIrqEn = 1'b0;
    d = 8'($urandom() & 32'hff);
    rxFrame(d);
    chk("hdlcIrq", {7'h0, hdlcIrq}, 8'h00);
    globalIrqEn = 1'b1;
    @(negedge mclk);
    @(negedge mclk);
    chk("hdlcIrq", {7'h0, hdlcIrq}, 8'h01);
    rd(ST, 8'h01);
    rd(SRC, 8'h02);
    @(negedge mclk);
    chk("hdlcIrq", {7'h0, hdlcIrq}, 8'h00);
    rd(RXH, d);
    wr(IE, 8'hff);
    txCtrl = framer_pkg::TXCTL_DATA_ONLY;
    d = 8'($urandom() & 32'hff);
    wr(TXH, d);
    chk("txHoldByte", txHoldByte, d);
    partner.txByte(1'b0);
    settle();
    rd(SRC, 8'h01);
    chk("hdlcIrq", {7'h0, hdlcIrq}, 8'h01);
    wr(TXH, 8'h3c);
    rd(SRC, 8'h00);
    partner.txByte(1'b1);
    settle();
    rd(SRC, 8'h00);
    partner.txByte(1'b0);
    settle();
    partner.txByte(1'b0);
    settle();
    rd(SRC, 8'h05);
    rd(ST, 8'h20);
    chk("sendDataClr", 8'(clrCount), 8'h01);
    wr(TXH, 8'h5a);
    wr(IE, 8'hdf);
    partner.txByte(1'b0);
    settle();
    rd(SRC, 8'h00);
    wr(IE, 8'h7f);
    wr(TXH, 8'h99);
    partner.txByte(1'b0);
    settle();
    rd(SRC, 8'h01);
    chk("hdlcIrq", {7'h0, hdlcIrq}, 8'h00);
    // zero delete off: a zero after five ones stays data
    zeroDelEn = 1'b0;
    partner.bits(16'h007e, 8, 1'b0);
    partner.bits(16'h00df, 8, 1'b0);
    settle();
    zeroDelEn = 1'b1;
    rd(RXH, 8'hdf);
    rd(ST, 8'h01);
    // crc failure pulses set status and new status
    @(negedge mclk);
    crc16Bad = 1'b1;
    @(negedge mclk);
    crc16Bad = 1'b0;
    crc32Bad = 1'b1;
    @(negedge mclk);
    crc32Bad = 1'b0;
    chk("hdlcIrq", {7'h0, hdlcIrq}, 8'h01);
    rd(ST, 8'hc0);
    rd(SRC, 8'h01);
    repeat (3) @(negedge mclk);
    print_verdict();
  end
endmodule : tb_top
